// file: hw/pwm_timer_defs.svh
// Register offsets, field positions, reset values and timing counts of the PWM timer
`ifndef PWM_TIMER_DEFS_SVH
`define PWM_TIMER_DEFS_SVH

`define OFS_CONTROL       12'h000
`define OFS_HIGH_RELOAD   12'h004
`define OFS_LOW_RELOAD    12'h008
`define OFS_PERIOD        12'h00C
`define OFS_CLOCK_CTRL    12'h010
`define OFS_FREEZE_SET    12'h014
`define OFS_FREEZE_CLEAR  12'h018
`define OFS_STATUS        12'h01C

`define CTRL_RUN_BIT      0
`define CTRL_FAST_BIT     1
`define CTRL_DIV10_BIT    2
`define CTRL_CLKOUT_BIT   3
`define CLK_ENABLE_BIT    0
`define CLK_DIV_LSB       1
`define FREEZE_TIMER_BIT  0

`define RESET_WORD        16'h0000
`define DIV10_TERMINAL    4'h9
`define SYS_CLOCK_HZ      50000000
`define SLOW_CLOCK_HZ     32000
`define FAST_CLOCK_HZ     16000000
`define SLOW_TICK_CYCLES  (`SYS_CLOCK_HZ / `SLOW_CLOCK_HZ)
`define FAST_TICK_CYCLES  (`SYS_CLOCK_HZ / `FAST_CLOCK_HZ)

`endif

// file: hw/pwm_timer_pkg.sv
// Types shared by the PWM timer
package pwm_timer_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_HIGH  = 3'b010,
      ST_LOW   = 3'b100
   } phase_t;

   typedef struct packed {
      logic [3:0]  control;
      logic [2:0]  clock_ctrl;
      logic        frozen;
      logic [15:0] high_phase_reload;
      logic [15:0] low_phase_reload;
      logic [15:0] interrupt_period_value;
      logic [15:0] high_shadow;
      logic [15:0] low_shadow;
      logic [15:0] phase_counter;
      logic [15:0] period_counter;
      phase_t      phase;
      logic        started;
      logic [10:0] prescale;
      logic [3:0]  div10;
      logic        sq_wave;
      logic        primary_pulse_output;
      logic        inverted_pulse_output;
      logic        timer_interrupt;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } timer_state_t;

endpackage

// file: hw/dual_counter_pwm_timer.sv
// Dual down-counter PWM timer with APB register access
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "pwm_timer_defs.svh"

// Summary of operation
// - A 16-bit phase counter, a 16-bit period counter and three reload registers reset to zero.
// - The count tick is 32 kHz by default or 16/8/4/2 MHz when fast select and clock enable are set.
// - An optional fixed divide by ten slows only the period counter tick.
// - Setting run raises the interrupt, loads both counters and then decrements them per tick.
// - At zero the phase counter reloads alternately from the high and low shadow values.
// - The primary output is high in the high phase, low in the low phase, and the other is its inverse while run is set.
// - In clock-output mode the high phase carries the tick clock divided by two at 50 percent duty.
// - A zero period counter waits for phase zero in a low phase, then interrupts and reloads both.
// - Reload writes reach the shadows only at start and when both counters are zero at the end of a low phase.
// - At start both counters and the primary output are low so an interrupt is issued at once.
// - While not running all state resets except the three reload registers, control, clock control and the freeze flag.
// - Reads at the period address give the period counter, at reload addresses the phase counter.
// - The freeze-set bit halts all counting and the freeze-clear bit resumes from held values.
// - The interrupt comes at the first cycle end after the period counter has counted down to zero.
module dual_counter_pwm_timer
   import pwm_timer_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             primary_pulse_output,
   output logic             inverted_pulse_output,
   output logic             timer_interrupt
);

   localparam logic [10:0] SLOW_TICK = 11'(`SLOW_TICK_CYCLES - 1);
   localparam logic [10:0] FAST_TICK = 11'(`FAST_TICK_CYCLES - 1);

   timer_state_t s;
   timer_state_t next_s;
   apb_req_t     req;

   logic        run;
   logic        fast;
   logic [10:0] tick_limit;
   logic        tick;
   logic        period_tick;
   logic        wr;
   logic        rd;
   logic        cycle_end;

   always_comb begin
      req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
   end

   // Tick selection; the fast rate is scaled from 16 MHz by the peripheral divider
   always_comb begin
      run  = s.control[`CTRL_RUN_BIT];
      fast = s.control[`CTRL_FAST_BIT] && s.clock_ctrl[`CLK_ENABLE_BIT];
      tick_limit = fast ? 11'(((32'(FAST_TICK) + 32'd1)
                   << s.clock_ctrl[`CLK_DIV_LSB +: 2]) - 32'd1) : SLOW_TICK;
      tick = run && !s.frozen && (s.prescale == tick_limit);
      period_tick = tick && (!s.control[`CTRL_DIV10_BIT]
                    || s.div10 == `DIV10_TERMINAL);
      wr = req.psel && req.penable && req.pwrite;
      rd = req.psel && !req.penable && !req.pwrite;
      cycle_end = (s.phase == ST_LOW) && (s.phase_counter == `RESET_WORD)
                  && (s.period_counter == `RESET_WORD);
   end

   // Next-state logic for bus, counters and outputs
   // Every output is set here from the state after the coming edge, so the
   // registered pins never lag the phase that they report. The start branch
   // drives the outputs as well; otherwise the first high phase would show one
   // clock short on the pin.
   always_comb begin
      next_s = s;
      next_s.pready  = req.psel && !req.penable; // One wait-free access phase
      next_s.pslverr = 1'b0;
      next_s.timer_interrupt = 1'b0;

      // Register writes take effect in the access cycle
      if (wr) begin
         unique case (req.paddr)
            `OFS_CONTROL:      next_s.control = req.pwdata[3:0];
            `OFS_HIGH_RELOAD:  next_s.high_phase_reload = req.pwdata[15:0];
            `OFS_LOW_RELOAD:   next_s.low_phase_reload = req.pwdata[15:0];
            `OFS_PERIOD:       next_s.interrupt_period_value = req.pwdata[15:0];
            `OFS_CLOCK_CTRL:   next_s.clock_ctrl = req.pwdata[2:0];
            `OFS_FREEZE_SET: begin
               if (req.pwdata[`FREEZE_TIMER_BIT]) next_s.frozen = 1'b1;
            end
            `OFS_FREEZE_CLEAR: begin
               if (req.pwdata[`FREEZE_TIMER_BIT]) next_s.frozen = 1'b0;
            end
            `OFS_STATUS: ;
            default: ;
         endcase
      end

      // Read data captured in setup so it stands in the access phase
      if (rd) begin
         unique case (req.paddr)
            `OFS_CONTROL:      next_s.prdata = {28'h0000000, s.control};
            `OFS_HIGH_RELOAD:  next_s.prdata = {16'h0000, s.phase_counter};
            `OFS_LOW_RELOAD:   next_s.prdata = {16'h0000, s.phase_counter};
            `OFS_PERIOD:       next_s.prdata = {16'h0000, s.period_counter};
            `OFS_CLOCK_CTRL:   next_s.prdata = {29'h00000000, s.clock_ctrl};
            `OFS_FREEZE_SET:   next_s.prdata = {31'h00000000, s.frozen};
            `OFS_FREEZE_CLEAR: next_s.prdata = {31'h00000000, s.frozen};
            `OFS_STATUS:       next_s.prdata = {29'h00000000, s.phase};
            default: begin
               next_s.prdata  = 32'h00000000;
            end
         endcase
      end
      if (req.psel && !req.penable) begin
         next_s.pslverr = (req.paddr > `OFS_STATUS) || (req.paddr[1:0] != 2'h0);
      end

      if (!run) begin
         // Disabled: everything but the programmed values held in reset
         next_s.frozen = s.frozen;
         next_s.high_shadow = `RESET_WORD;
         next_s.low_shadow = `RESET_WORD;
         next_s.phase_counter = `RESET_WORD;
         next_s.period_counter = `RESET_WORD;
         next_s.phase = ST_IDLE;
         next_s.started = 1'b0;
         next_s.prescale = 11'h000;
         next_s.div10 = 4'h0;
         next_s.sq_wave = 1'b0;
         next_s.primary_pulse_output = 1'b0;
      end else if (!s.started) begin
         // Start-up counts as a finished cycle: interrupt and load at once
         next_s.started = 1'b1;
         next_s.timer_interrupt = 1'b1;
         next_s.high_shadow = s.high_phase_reload;
         next_s.low_shadow = s.low_phase_reload;
         next_s.phase_counter = s.high_phase_reload;
         next_s.period_counter = s.interrupt_period_value;
         next_s.phase = ST_HIGH;
         next_s.prescale = 11'h000;
         // High phase begins now, so the pin goes with it
         next_s.primary_pulse_output = s.control[`CTRL_CLKOUT_BIT] ? s.sq_wave : 1'b1;
      end else if (!s.frozen) begin
         next_s.prescale = tick ? 11'h000 : s.prescale + 11'h001;
         if (tick && s.control[`CTRL_DIV10_BIT]) begin
            next_s.div10 = (s.div10 == `DIV10_TERMINAL) ? 4'h0 : s.div10 + 4'h1;
         end
         if (tick) begin
            next_s.sq_wave = ~s.sq_wave;
            if (cycle_end) begin
               next_s.timer_interrupt = 1'b1;
               next_s.high_shadow = s.high_phase_reload;
               next_s.low_shadow = s.low_phase_reload;
               next_s.phase_counter = s.high_phase_reload;
               next_s.period_counter = s.interrupt_period_value;
               next_s.phase = ST_HIGH;
               next_s.div10 = 4'h0;
            end else begin
               if (s.phase_counter == `RESET_WORD) begin
                  // Zero is a counted tick, so each phase lasts reload plus one
                  next_s.phase = (s.phase == ST_HIGH) ? ST_LOW : ST_HIGH;
                  next_s.phase_counter = (s.phase == ST_HIGH) ? s.low_shadow
                                         : s.high_shadow;
               end else begin
                  next_s.phase_counter = s.phase_counter - 16'h0001;
               end
               if (period_tick && s.period_counter != `RESET_WORD) begin
                  next_s.period_counter = s.period_counter - 16'h0001;
               end
            end
         end
         // Output follows the phase after this tick
         unique case (next_s.phase)
            ST_HIGH: next_s.primary_pulse_output =
                     s.control[`CTRL_CLKOUT_BIT] ? next_s.sq_wave : 1'b1;
            ST_LOW:  next_s.primary_pulse_output = 1'b0;
            ST_IDLE: next_s.primary_pulse_output = 1'b0;
         endcase
      end
      next_s.inverted_pulse_output = ~next_s.primary_pulse_output & run;
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '{phase: ST_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign primary_pulse_output = s.primary_pulse_output;
   assign inverted_pulse_output = s.inverted_pulse_output;
   assign timer_interrupt = s.timer_interrupt;

   // Checks
   // All checks share the one clock; reset disables them, so the first cycle
   // after reset is looked at through the falling edge of the reset itself.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Reset leaves counters and programmed values at zero
   reset_zero_a: assert property ($fell(rst) |-> s.phase_counter == 16'h0000
      && s.high_phase_reload == 16'h0000)
      else $error("counters not zero after reset");

   // Start interrupt follows the run bit by one clock
   start_irq_a: assert property ($rose(run) && !s.started |=> timer_interrupt)
      else $error("no interrupt at start");

   // Start loads the high reload into the phase counter
   start_load_a: assert property ($rose(s.started) |-> s.phase_counter == $past(s.high_phase_reload)
      && s.phase == ST_HIGH)
      else $error("phase counter not loaded at start");

   // Second output is the inverse of the first while running
   inverse_out_a: assert property (run && s.started |-> inverted_pulse_output
      == !primary_pulse_output)
      else $error("outputs not inverse");

   // Low phase always shows a low pin
   low_output_a: assert property (s.phase == ST_LOW |-> !primary_pulse_output)
      else $error("output high in low phase");

   // Disabled timer is held in reset
   disabled_hold_a: assert property (!run |=> s.phase_counter == 16'h0000
      && s.period_counter == 16'h0000 && !primary_pulse_output)
      else $error("state not held in reset while disabled");

   // Frozen counters do not move
   freeze_hold_a: assert property (s.frozen && s.started && $past(s.frozen)
      |-> $stable(s.phase_counter) && $stable(s.period_counter))
      else $error("counter moved while frozen");

   // Cycle end raises the interrupt and reloads the period counter
   wrap_irq_a: assert property (tick && cycle_end && s.started |=> timer_interrupt
      && s.period_counter == $past(s.interrupt_period_value))
      else $error("no interrupt at cycle end");

   // After start, shadows change only at a cycle end
   shadow_keep_a: assert property (s.started && !(tick && cycle_end) && run
      |=> $stable(s.high_shadow))
      else $error("shadow changed mid cycle");

   // High phase hands over to the low shadow at zero
   phase_swap_a: assert property (tick && !cycle_end && s.started && s.phase == ST_HIGH
      && s.phase_counter == 16'h0000 |=> s.phase == ST_LOW
      && s.phase_counter == $past(s.low_shadow))
      else $error("phase did not swap");

   // Period address reads the live period counter
   period_read_a: assert property (rd && paddr == `OFS_PERIOD && !s.frozen |=>
      prdata[15:0] == $past(s.period_counter))
      else $error("period read wrong");

   // Every setup cycle is answered in the very next cycle; a master that
   // waits longer would stall, so the bus must never insert wait states.
   ready_next_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");

   // Ready stands one cycle only, so a back-to-back setup is not taken twice
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");

   // Addresses above the map are refused with an error answer
   refuse_high_a: assert property (psel && !penable && paddr > `OFS_STATUS |=> pslverr)
      else $error("unmapped address accepted");

   // A period write lands at the edge that closes the access phase
   period_write_a: assert property (wr && paddr == `OFS_PERIOD
      |=> s.interrupt_period_value == $past(pwdata[15:0]))
      else $error("period write lost");

   // A stopped timer raises no interrupt at all
   idle_irq_a: assert property (!run |=> !timer_interrupt)
      else $error("interrupt while stopped");

   // The interrupt is a pulse; software counts pulses, not levels
   irq_pulse_a: assert property (timer_interrupt |=> !timer_interrupt)
      else $error("interrupt longer than a cycle");

   // Once started, freeze suppresses interrupts as well as counting
   freeze_quiet_a: assert property (s.frozen && s.started |=> !timer_interrupt)
      else $error("interrupt while frozen");

   // An empty period counter waits for the end of the low phase
   period_wait_a: assert property (tick && !cycle_end && s.started
      && s.period_counter == 16'h0000 |=> s.period_counter == 16'h0000)
      else $error("period counter left zero early");

   // High phase shows a steady high level outside clock-output mode;
   // a control write or freeze in the previous cycle may leave a stale pin
   high_output_a: assert property (s.phase == ST_HIGH && !s.control[`CTRL_CLKOUT_BIT]
      && $stable(s.control) && !$past(s.frozen) |-> primary_pulse_output)
      else $error("output low in high phase");

   // Clock-output mode puts the halved tick clock on the pin during the high phase
   clkout_wave_a: assert property (s.phase == ST_HIGH && s.control[`CTRL_CLKOUT_BIT]
      && $stable(s.control) && !$past(s.frozen) |-> primary_pulse_output == s.sq_wave)
      else $error("square wave missing in high phase");

   // With the divider on, nine of ten ticks leave the period counter alone
   div_skip_a: assert property (tick && s.control[`CTRL_DIV10_BIT] && !cycle_end
      && s.div10 != `DIV10_TERMINAL |=> $stable(s.period_counter))
      else $error("period counter ran undivided");

   // Low shadow takes the programmed value at a cycle end
   shadow_load_a: assert property (tick && cycle_end && s.started
      |=> s.low_shadow == $past(s.low_phase_reload))
      else $error("low shadow not loaded");

   // Main scenarios
   start_c: cover property ($rose(s.started));
   cycle_c: cover property (tick && cycle_end);
   freeze_c: cover property ($fell(s.frozen) && run);
   clkout_c: cover property (s.control[`CTRL_CLKOUT_BIT] && $rose(primary_pulse_output));
   div_c: cover property (period_tick && s.control[`CTRL_DIV10_BIT]);

endmodule

// file: test/test_dual_counter_pwm_timer.sv
// Self-checking testbench of the dual down-counter PWM timer
`timescale 1ns/100ps
`include "pwm_timer_defs.svh"

module test_dual_counter_pwm_timer;
   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        primary_pulse_output;
   logic        inverted_pulse_output;
   logic        timer_interrupt;
   logic [32:0] exp_q[$];
   logic        running;
   int          num_errors;
   int          checks_done;
   int          n;
   int          m_val;
   int          n_val;
   int          tick;

   dual_counter_pwm_timer dut (
      .clk                   (clk),
      .rst                   (rst),
      .psel                  (psel),
      .penable               (penable),
      .pwrite                (pwrite),
      .paddr                 (paddr),
      .pwdata                (pwdata),
      .prdata                (prdata),
      .pready                (pready),
      .pslverr               (pslverr),
      .primary_pulse_output  (primary_pulse_output),
      .inverted_pulse_output (inverted_pulse_output),
      .timer_interrupt       (timer_interrupt)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] expd);
      checks_done++;
      if (seen !== expd) begin
         num_errors++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One APB transfer; a read notes its expected {pslverr, prdata} for the monitor
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      if (!w)
         exp_q.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         num_errors++;
         print_verdict();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Read answers are matched in order against the notes of the driver
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0)
            check(33'h1_FFFF_FFFF, 33'h0);
         else
            check({pslverr, prdata}, exp_q.pop_front());
      end
      if (running)
         check(inverted_pulse_output, !primary_pulse_output);
   end

   function automatic logic sig(input int k);
      return (k == 0) ? primary_pulse_output : timer_interrupt;
   endfunction

   // Counts cycles until a signal reaches a level; a long wait is a failure
   task automatic count_until(input int k, input logic lvl, input int lim, output int c);
      c = 0;
      while (sig(k) !== lvl && c < lim) begin
         @(posedge clk);
         c++;
      end
      if (c >= lim) begin
         num_errors++;
         print_verdict();
      end
   endtask

   // Stops, programs and restarts the timer, then expects the start interrupt
   // Mode bits are clock-output, divide-by-ten and fast select
   task automatic start(input int m, input int nn, input int on, input logic [2:0] fast);
      running = 1'b0;
      apb(1'b1, `OFS_CONTROL, 32'h0000_0000, 33'h0);
      apb(1'b1, `OFS_HIGH_RELOAD, m, 33'h0);
      apb(1'b1, `OFS_LOW_RELOAD, nn, 33'h0);
      apb(1'b1, `OFS_PERIOD, on, 33'h0);
      apb(1'b1, `OFS_CLOCK_CTRL, 32'h0000_0001, 33'h0);
      apb(1'b1, `OFS_CONTROL, {28'h0, fast, 1'b1}, 33'h0);
      count_until(1, 1'b1, 10, n);
      check(timer_interrupt, 1'b1);
      running = 1'b1;
   endtask

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      running = 1'b0;
      num_errors = 0;
      checks_done = 0;
      void'($urandom(16409));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values, idle status and a refused address
      apb(1'b0, `OFS_HIGH_RELOAD, 32'h0, 33'h0_0000_0000);
      apb(1'b0, `OFS_PERIOD, 32'h0, 33'h0_0000_0000);
      apb(1'b0, `OFS_STATUS, 32'h0, 33'h0_0000_0001);
      apb(1'b0, 12'h020, 32'h0, 33'h1_0000_0000);
      check({primary_pulse_output, inverted_pulse_output, timer_interrupt}, 3'h0);
      // Phase lengths on the fast tick with random reloads
      for (int i = 0; i < 4; i++) begin
         m_val = $urandom_range(3);
         n_val = $urandom_range(3);
         start(m_val, n_val, 0, 1'b1);
         count_until(0, 1'b1, 200, n);
         count_until(0, 1'b0, 200, n);
         check(n, (m_val + 1) * `FAST_TICK_CYCLES);
         count_until(0, 1'b1, 200, n);
         check(n, (n_val + 1) * `FAST_TICK_CYCLES);
      end
      // Interrupt spacing for one and for two PWM cycles per period
      for (int on = 0; on < 10; on += 9) begin
         start(2, 1, on, 1'b1);
         @(posedge clk);
         count_until(1, 1'b1, 200, n);
         @(posedge clk);
         count_until(1, 1'b1, 200, n);
         check(n + 1, (on == 0 ? 15 : 30));
      end
      // Slow default tick
      start(0, 0, 0, 1'b0);
      count_until(0, 1'b1, 4000, n);
      count_until(0, 1'b0, 4000, n);
      check(n, `SLOW_TICK_CYCLES);
      // Divide by ten: one period step per ten ticks, so three cycles per interrupt
      start(2, 1, 1, 3'b011);
      @(posedge clk);
      count_until(1, 1'b1, 200, n);
      @(posedge clk);
      count_until(1, 1'b1, 200, n);
      check(n + 1, 45);
      // Clock-output mode: the high phase carries a tick-wide pulse
      start(2, 1, 0, 3'b101);
      count_until(0, 1'b1, 200, n);
      count_until(0, 1'b0, 200, n);
      check(n, `FAST_TICK_CYCLES);
      // Freeze holds the output, clearing it resumes the pulses
      start(2, 1, 0, 1'b1);
      apb(1'b1, `OFS_FREEZE_SET, 32'h0000_0001, 33'h0);
      apb(1'b0, `OFS_FREEZE_SET, 32'h0, 33'h0_0000_0001);
      tick = primary_pulse_output;
      n = 0;
      repeat (40) begin
         @(posedge clk);
         if (primary_pulse_output !== tick[0] || timer_interrupt !== 1'b0)
            n++;
      end
      check(n, 0);
      apb(1'b1, `OFS_FREEZE_CLEAR, 32'h0000_0001, 33'h0);
      count_until(0, ~tick[0], 40, n);
      check(primary_pulse_output, !tick[0]);
      // Stopping clears counters and outputs
      running = 1'b0;
      apb(1'b1, `OFS_CONTROL, 32'h0000_0000, 33'h0);
      apb(1'b0, `OFS_PERIOD, 32'h0, 33'h0_0000_0000);
      apb(1'b0, `OFS_LOW_RELOAD, 32'h0, 33'h0_0000_0000);
      check({primary_pulse_output, inverted_pulse_output}, 2'h0);
      print_verdict();
   end
endmodule
